// ===== hdl/tcim_flags.sv
// sticky event flags, cleared by a status read; a new event wins over the clear
`timescale 1ns/1ps
module tcim_flags (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire tcim_pkg::tcim_events_s events,
    input  wire logic                  wave_mode,
    input  wire logic                  clear_rd,
    output logic [7:0]                 flags
);
    import tcim_pkg::*;
    typedef struct packed {
        logic [7:0] flag;
    } tcim_flags_s;
    tcim_flags_s st_r;
    tcim_flags_s st_nxt;
    logic [7:0]  ev_vec;
    logic [7:0]  ev_ok;

    // pack events and drop those that do not apply to the current mode
    always_comb begin
        ev_vec = {events.external_trigger, events.second_load, events.first_load,
                  events.period_compare, events.second_compare, events.first_compare,
                  events.load_overrun, events.counter_overflow};
        ev_ok  = ev_vec & (wave_mode ? ~TCIM_CAPT_ONLY : ~TCIM_WAVE_ONLY);
        st_nxt = st_r;
        if (clear_rd) begin
            st_nxt.flag = TCIM_FLAG_RST;
        end
        st_nxt.flag = st_nxt.flag | ev_ok;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flags = st_r.flag;
endmodule // tcim_flags

// ===== hdl/tcim_pkg.sv
// package: register map, field layout and carrier types of the timer channel interrupt block
package tcim_pkg;
    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0]  TCIM_OFF_STATUS  = 8'h00;
    localparam logic [7:0]  TCIM_OFF_ENABLE  = 8'h04;
    localparam logic [7:0]  TCIM_OFF_DISABLE = 8'h08;
    localparam logic [7:0]  TCIM_OFF_MASK    = 8'h0c;
    localparam logic [7:0]  TCIM_OFF_MODE    = 8'h10;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int TCIM_B_OVFL   = 0;
    localparam int TCIM_B_OVRUN  = 1;
    localparam int TCIM_B_CMP1   = 2;
    localparam int TCIM_B_CMP2   = 3;
    localparam int TCIM_B_PERIOD = 4;
    localparam int TCIM_B_LOAD1  = 5;
    localparam int TCIM_B_LOAD2  = 6;
    localparam int TCIM_B_TRIG   = 7;
    localparam int TCIM_B_MIR1   = 17;
    localparam int TCIM_B_MIR2   = 18;
    localparam int TCIM_NSRC     = 8;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]  TCIM_MASK_RST  = 8'h00;
    localparam logic [7:0]  TCIM_FLAG_RST  = 8'h00;
    // sources valid only in capture mode / only in waveform mode
    localparam logic [7:0]  TCIM_CAPT_ONLY = 8'h62;
    localparam logic [7:0]  TCIM_WAVE_ONLY = 8'h0c;

    // event strobes from the channel datapath, one cycle each
    typedef struct packed {
        logic counter_overflow;
        logic load_overrun;
        logic first_compare;
        logic second_compare;
        logic period_compare;
        logic first_load;
        logic second_load;
        logic external_trigger;
    } tcim_events_s;

    // ahb address phase held for the data phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } tcim_aphase_s;
endpackage

// ===== hdl/tcim_sync.sv
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
module tcim_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin,
    output logic      level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } tcim_sync_s;
    tcim_sync_s st_r;
    tcim_sync_s st_nxt;

    // stage one feeds stage two only; the level moves when two and three agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.lvl = st_r.s3;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.lvl;
endmodule // tcim_sync

// ===== hdl/tcim_top.sv
// timer channel interrupt enable/disable/mask logic with line mirrors on ahb-lite
// Overview of operation
// - enable write sets mask bits written one
// - disable write clears mask bits written one
// - overflow bit 0, overrun bit 1 capture
// - first compare bit 2, waveform only
// - second compare bit 3, waveform only
// - first load bit 5, capture only
// - second load bit 6, capture only
// - period compare, trigger in both modes
// - mask register reads enabled sources
// - capture mode: line A mirror shows pin
// - waveform mode: line A mirror shows drive
// - line B mirror: pin or drive
// - flags stick until status read clears
// - mode select 0 capture, 1 waveform
//
// register map (byte offsets, one word each)
//   0x00 status  read clears flags 7:0; bit 17 line_first_mirror, bit 18 line_second_mirror
//   0x04 enable  write ones to set mask bits, zeros have no effect
//   0x08 disable write ones to clear mask bits, zeros have no effect
//   0x0c mask    read only, same layout as enable and disable
//   0x10 mode    bit 0 waveform select, read and write
//   others       read as zero, writes ignored, response always okay
//
// interrupt source layout, common to status, enable, disable and mask
//   bit 0 counter overflow      both modes
//   bit 1 load overrun          capture mode only
//   bit 2 first compare         waveform mode only
//   bit 3 second compare        waveform mode only
//   bit 4 period compare        both modes
//   bit 5 first load            capture mode only
//   bit 6 second load           capture mode only
//   bit 7 external trigger      both modes
//
// bus timing
//   zero wait states; hreadyout is tied high and hresp is always okay
//   a write lands at the edge that closes its data phase
//   read data is registered at the edge that closes the address phase
//   a status read clears the flags at that same edge, so an event that
//   arrives while the address phase stands is kept for the next read
//   rather than being wiped unseen
//   mask bits may be set for any source in either mode; a source that
//   does not apply to the current mode simply never raises its flag
//   flags already set are kept across a mode change until read
//
// limitations
//   hsize is not checked: every access is taken as a whole word
//   only address bits 7:0 are decoded, so the map repeats every 256 bytes
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module tcim_top (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic [31:0]                 hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire tcim_pkg::tcim_events_s events,
    input  wire logic                   io_line_first_in,
    input  wire logic                   io_line_second_in,
    input  wire logic                   io_line_first_drive,
    input  wire logic                   io_line_second_drive,
    output logic                        wave_mode,
    output logic                        irq
);
    import tcim_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        tcim_aphase_s ap;
        logic [7:0]   mask;
        logic         wave;
        logic [31:0]  rdata;
    } tcim_top_s;
    tcim_top_s st_r;
    tcim_top_s st_nxt;

    logic       pin_a;
    logic       pin_b;
    logic [7:0] flags;
    logic       stat_rd;
    logic       mir_a;
    logic       mir_b;

    // ************************************************************
    // pin synchronisers and flags
    // ************************************************************
    tcim_sync u_sync_a (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (io_line_first_in),
        .level   (pin_a)
    );
    tcim_sync u_sync_b (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (io_line_second_in),
        .level   (pin_b)
    );
    tcim_flags u_flags (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .events    (events),
        .wave_mode (st_r.wave),
        .clear_rd  (stat_rd),
        .flags     (flags)
    );

    // decode an offset of the registered address phase
    function automatic logic hit(input tcim_aphase_s a, input logic [7:0] off);
        hit = a.valid && (a.addr == off);
    endfunction

    // mirrors: pin level in capture mode, driven level in waveform mode
    assign mir_a = st_r.wave ? io_line_first_drive : pin_a;
    assign mir_b = st_r.wave ? io_line_second_drive : pin_b;
    // a status read clears the flags at the edge that registers its read data;
    // clearing one cycle later would wipe an event of the address phase unseen
    assign stat_rd = hsel && hready && htrans[1] && !hwrite &&
                     (haddr[7:0] == TCIM_OFF_STATUS);

    // ************************************************************
    // bus slave and registers
    // ************************************************************
    // zero wait states: address captured, write applied or read data registered
    always_comb begin
        logic [31:0] rd;
        rd = 32'h0000_0000;
        st_nxt = st_r;
        st_nxt.ap.valid = hsel && hready && htrans[1];
        st_nxt.ap.write = hwrite;
        st_nxt.ap.addr  = haddr[7:0];
        if (st_r.ap.valid && st_r.ap.write) begin
            // set-only and clear-only ports avoid read-modify-write races with isrs
            if (hit(st_r.ap, TCIM_OFF_ENABLE)) begin
                st_nxt.mask = st_r.mask | hwdata[7:0];
            end
            if (hit(st_r.ap, TCIM_OFF_DISABLE)) begin
                st_nxt.mask = st_r.mask & ~hwdata[7:0];
            end
            if (hit(st_r.ap, TCIM_OFF_MODE)) begin
                st_nxt.wave = hwdata[0];
            end
        end
        if (st_nxt.ap.valid && !hwrite) begin
            unique case (haddr[7:0])
                TCIM_OFF_STATUS: begin
                    rd[7:0]         = flags;
                    rd[TCIM_B_MIR1] = mir_a;
                    rd[TCIM_B_MIR2] = mir_b;
                end
                TCIM_OFF_MASK: rd[7:0] = st_r.mask;
                TCIM_OFF_MODE: rd[0] = st_r.wave;
                default: rd = 32'h0000_0000;
            endcase
        end
        st_nxt.rdata = rd;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0; // mask at zero: nothing enabled
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign hrdata    = st_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wave_mode = st_r.wave;
    // level interrupt while any enabled flag stands
    assign irq       = |(flags & st_r.mask);

    // ************************************************************
    // checks
    // ************************************************************
    // mask ports: set-only and clear-only, nothing else moves the mask
    enable_sets_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hit(st_r.ap, TCIM_OFF_ENABLE) && st_r.ap.write) |=>
        ((st_r.mask & $past(hwdata[7:0])) == $past(hwdata[7:0])))
        else $error("enable write did not set mask");
    enable_keeps_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hit(st_r.ap, TCIM_OFF_ENABLE) && st_r.ap.write) |=>
        ((st_r.mask & $past(st_r.mask)) == $past(st_r.mask)))
        else $error("enable write cleared a mask bit");
    disable_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hit(st_r.ap, TCIM_OFF_DISABLE) && st_r.ap.write) |=>
        ((st_r.mask & $past(hwdata[7:0])) == 8'h00))
        else $error("disable write did not clear mask");
    disable_keeps_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hit(st_r.ap, TCIM_OFF_DISABLE) && st_r.ap.write) |=>
        ((st_r.mask | $past(st_r.mask)) == $past(st_r.mask)))
        else $error("disable write set a mask bit");
    mask_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(st_r.ap.valid && st_r.ap.write) |=>
        $stable(st_r.mask))
        else $error("mask changed without a write");
    mask_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hsel && hready && htrans[1] && !hwrite && (haddr[7:0] == TCIM_OFF_MASK)) |=>
        (hrdata == {24'h00_0000, $past(st_r.mask)}))
        else $error("mask read returned a wrong value");
    mask_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(hresetn) |->
        ((st_r.mask == TCIM_MASK_RST) && (flags == TCIM_FLAG_RST)))
        else $error("mask or flags not clear after reset");
    // interrupt line follows enabled flags
    irq_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ($past(irq) && !$past(stat_rd) && ($past(st_r.mask) == st_r.mask)) |->
        irq)
        else $error("irq dropped with flags and mask kept");
    irq_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (stat_rd && (events == '0)) |=>
        !irq)
        else $error("irq still high after status read");
    // each source raises its flag in the modes where it applies
    ovfl_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        events.counter_overflow |=>
        flags[TCIM_B_OVFL])
        else $error("overflow flag not set");
    ovrun_capt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (events.load_overrun && !st_r.wave) |=>
        flags[TCIM_B_OVRUN])
        else $error("overrun flag not set in capture mode");
    cmp1_wave_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (events.first_compare && st_r.wave) |=>
        flags[TCIM_B_CMP1])
        else $error("first compare flag not set in waveform mode");
    cmp2_wave_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (events.second_compare && st_r.wave) |=>
        flags[TCIM_B_CMP2])
        else $error("second compare flag not set in waveform mode");
    load1_capt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (events.first_load && !st_r.wave) |=>
        flags[TCIM_B_LOAD1])
        else $error("first load flag not set in capture mode");
    load2_capt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (events.second_load && !st_r.wave) |=>
        flags[TCIM_B_LOAD2])
        else $error("second load flag not set in capture mode");
    period_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        events.period_compare |=>
        flags[TCIM_B_PERIOD])
        else $error("period compare flag not set");
    trig_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        events.external_trigger |=>
        flags[TCIM_B_TRIG])
        else $error("trigger flag not set");
    // sources of the other mode never raise a flag
    wave_flags_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r.wave && $past(st_r.wave) && stat_rd) |=>
        ((flags & TCIM_CAPT_ONLY) == 8'h00))
        else $error("capture flag set in waveform mode");
    capt_flags_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st_r.wave && !$past(st_r.wave) && stat_rd) |=>
        ((flags & TCIM_WAVE_ONLY) == 8'h00))
        else $error("compare flag set in capture mode");
    wave_src_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st_r.wave && ((flags & TCIM_WAVE_ONLY) == 8'h00)) |=>
        ((flags & TCIM_WAVE_ONLY) == 8'h00))
        else $error("compare flag rose in capture mode");
    capt_src_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r.wave && ((flags & TCIM_CAPT_ONLY) == 8'h00)) |=>
        ((flags & TCIM_CAPT_ONLY) == 8'h00))
        else $error("load flag rose in waveform mode");
    // a flag stays until a status read
    flag_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !stat_rd |=>
        ((flags & $past(flags)) == $past(flags)))
        else $error("flag dropped without status read");
    // mode register and line mirrors
    mode_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hit(st_r.ap, TCIM_OFF_MODE) && st_r.ap.write) |=>
        (st_r.wave == $past(hwdata[0])))
        else $error("mode write not applied");
    mirror_capt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st_r.wave && stat_rd) |=>
        (hrdata[TCIM_B_MIR1] == $past(pin_a)))
        else $error("first line mirror wrong in capture mode");
    mirror_wave_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r.wave && stat_rd) |=>
        (hrdata[TCIM_B_MIR1] == $past(io_line_first_drive)))
        else $error("first line mirror wrong in waveform mode");
    mirror_b_capt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st_r.wave && stat_rd) |=>
        (hrdata[TCIM_B_MIR2] == $past(pin_b)))
        else $error("second line mirror wrong in capture mode");
    mirror_b_wave_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r.wave && stat_rd) |=>
        (hrdata[TCIM_B_MIR2] == $past(io_line_second_drive)))
        else $error("second line mirror wrong in waveform mode");
endmodule // tcim_top

// ===== verification/tcim_bench.sv
// self-checking bench for the timer channel interrupt block
`timescale 1ns/1ps
module tcim_bench;
    import tcim_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hresp, stuck, wave_mode, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, pin_r, drv_r;
    logic [2:0]  hsize;
    tcim_events_s events;
    int err_count, check_count;

    tcim_master tcim_master_inst (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .stuck(stuck));
    tcim_top tcim_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .events(events),
        .io_line_first_in(pin_r[0]), .io_line_second_in(pin_r[1]),
        .io_line_first_drive(drv_r[0]), .io_line_second_drive(drv_r[1]),
        .wave_mode(wave_mode), .irq(irq));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one bus access; a hung bus ends the run
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        tcim_master_inst.xfer(wr, {24'h0, a}, wd, rd);
        if (stuck !== 1'b0) begin
            err_count++;
            stop_test();
        end
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    // one-cycle pulse of each source set in m (register layout), struct order reversed
    task automatic pulse(input logic [7:0] m);
        @(posedge hclk);
        for (int i = 0; i < 8; i++) events[7-i] <= m[i];
        @(posedge hclk);
        events <= '0;
        @(negedge hclk);
    endtask

    task automatic lines(input logic [1:0] p, input logic [1:0] d);
        @(posedge hclk);
        pin_r <= p;
        drv_r <= d;
        repeat (8) @(posedge hclk);
    endtask

    initial begin
        hresetn = 1'b0; events = '0; pin_r = 2'h0; drv_r = 2'h0;
        err_count = 0; check_count = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        // ************************************************************
        // mask set/clear
        // ************************************************************
        rd_chk("mask", TCIM_OFF_MASK, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        acc(1'b1, TCIM_OFF_ENABLE, 32'h0000_00a5);
        rd_chk("mask", TCIM_OFF_MASK, 32'h0000_00a5);
        acc(1'b1, TCIM_OFF_ENABLE, 32'h0000_005a);
        rd_chk("mask", TCIM_OFF_MASK, 32'h0000_00ff);
        acc(1'b1, TCIM_OFF_DISABLE, 32'h0000_000f);
        rd_chk("mask", TCIM_OFF_MASK, 32'h0000_00f0);
        acc(1'b1, TCIM_OFF_DISABLE, 32'h0);
        rd_chk("mask", TCIM_OFF_MASK, 32'h0000_00f0);
        $display("test mask done");
        // ************************************************************
        // flags by mode, sticky until read, interrupt
        // ************************************************************
        rd_chk("mode", TCIM_OFF_MODE, 32'h0);
        pulse(8'hff);
        chk("irq", 32'h1, {31'h0, irq});
        rd_chk("status", TCIM_OFF_STATUS, {24'h0, ~TCIM_WAVE_ONLY});
        @(negedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        rd_chk("status", TCIM_OFF_STATUS, 32'h0);
        acc(1'b1, TCIM_OFF_MODE, 32'h1);
        @(negedge hclk);
        chk("wave_mode", 32'h1, {31'h0, wave_mode});
        pulse(8'hff);
        rd_chk("status", TCIM_OFF_STATUS, {24'h0, ~TCIM_CAPT_ONLY});
        acc(1'b1, TCIM_OFF_DISABLE, 32'h0000_00ff);
        pulse(8'hff);
        chk("irq", 32'h0, {31'h0, irq});
        acc(1'b1, TCIM_OFF_ENABLE, 32'h0000_0008);
        @(negedge hclk);
        chk("irq", 32'h1, {31'h0, irq});
        rd_chk("status", TCIM_OFF_STATUS, {24'h0, ~TCIM_CAPT_ONLY});
        acc(1'b1, 8'h20, 32'h0000_00ff);
        rd_chk("unmapped", 8'h20, 32'h0);
        rd_chk("mask", TCIM_OFF_MASK, 32'h0000_0008);
        $display("test flags done");
        // ************************************************************
        // line mirrors: drive in waveform mode, pins in capture mode
        // ************************************************************
        lines(2'b01, 2'b10);
        rd_chk("status", TCIM_OFF_STATUS, 32'h0004_0000);
        acc(1'b1, TCIM_OFF_MODE, 32'h0);
        rd_chk("status", TCIM_OFF_STATUS, 32'h0002_0000);
        lines(2'b10, 2'b01);
        rd_chk("status", TCIM_OFF_STATUS, 32'h0004_0000);
        $display("test mirror done");
        stop_test();
    end
endmodule // tcim_bench

// ===== verification/tcim_master.sv
// bus master model: single ahb-lite word transfers on behalf of software
`timescale 1ns/1ps
module tcim_master (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    output logic             stuck
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
        stuck  = 1'b0;
    end

    // wait for hready at a rising edge; sampled just before the edge, as the edge sees it
    task automatic wait_ready(output logic [31:0] d);
        logic rdy;
        rdy = 1'b0;
        for (int i = 0; i < 16 && rdy !== 1'b1; i++) begin
            @(negedge hclk);
            rdy = hready;
            d   = hrdata;
            @(posedge hclk);
        end
        if (rdy !== 1'b1) stuck = 1'b1; // blocking: the caller looks at it in this step
    endtask

    // address phase held until taken, then data phase held until taken
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        logic [31:0] d;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready(d);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_ready(rd);
    endtask
endmodule // tcim_master
